// [logic/event_flag_bank.sv]
// Purpose: main-domain event and status register bank with interrupt request
// Assumes: the control bus frame decoder presents one access per strobe, with a
//          register index and 16-bit payload; event inputs are one-cycle or level
//          pulses synchronous to clk; live status inputs are synchronous levels
// Notes:   read data is registered, one cycle after the read strobe
module event_flag_bank
   import evflag_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   // register access from the control bus frame decoder
   input  wire logic              acc_wr,
   input  wire logic              acc_rd,
   input  wire logic [IDX_W-1:0]  acc_idx,
   input  wire logic [REG_W-1:0]  acc_wdata,
   output logic      [REG_W-1:0]  acc_rdata,
   output logic                   acc_rvalid,
   // events raised by the detectors
   input  wire logic [7:0]        overtemp_evt,
   input  wire logic [6:0]        overcurrent_evt,
   input  wire logic [2:0]        supply_uv_evt,
   input  wire logic [2:0]        prereg_evt,
   input  wire logic              prereg_feedback_ov_evt,
   input  wire logic              hv_linear_input_uv_evt,
   input  wire logic              standby_timer_evt,
   input  wire logic              boost_overvoltage_evt,
   input  wire logic              boost_uv_high_evt,
   input  wire logic              bias_rail_uvh_evt,
   input  wire logic              thermal_selftest_fail_evt,
   input  wire logic              central_thermal_evt,
   input  wire logic              invalid_access_evt,
   input  wire logic              crc_error_evt,
   // live levels
   input  wire logic              wake_input_one,
   input  wire logic              wake_input_two,
   input  wire logic              ext_clock_watchdog_good,
   input  wire logic [8:0]        regulator_on_state,
   // interrupt request toward the pin driver
   output logic                   irq_req
);

   logic [15:0] fault_set;
   logic [15:0] wake_set;
   logic [1:0]  bus_err_set;
   logic [15:0] fault_flags;
   logic [15:0] wake_flags;
   logic [1:0]  bus_err_flags;
   logic [1:0]  wake_rise;
   logic [15:0] live_status;
   logic        clock_good_ff;
   logic [2:0]  inhibit_ff;
   logic [15:0] rdata_ff;
   logic        rvalid_ff;
   logic [15:0] nxt_rdata;
   logic        unmapped_acc;
   logic        irq_ff;
   logic        nxt_irq;

   function automatic logic idx_hit(input logic [IDX_W-1:0] idx, input logic [2:0] want);
      idx_hit = (idx == want);
   endfunction

   function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
      idx_mapped = idx_hit(idx, IDX_REGULATOR_FAULT) || idx_hit(idx, IDX_SUPPLY_WAKE)
                || idx_hit(idx, IDX_LIVE_STATUS) || idx_hit(idx, IDX_IRQ_INHIBIT);
   endfunction

   // the port and signal widths below are fixed at sixteen bits
   if (REG_W != 16)
   begin : g_bad_reg_w
      $error("event_flag_bank: register payload must be 16 bits");
   end

   if (IDX_W < 2)
   begin : g_bad_idx_w
      $error("event_flag_bank: index too narrow for four registers");
   end

   if (IDX_IRQ_INHIBIT >= (1 << IDX_W))
   begin : g_bad_idx_range
      $error("event_flag_bank: inhibit index beyond index width");
   end

   if (POS_OVERTEMP_LO + 8 > POS_OVERCUR_LO)
   begin : g_bad_overtemp
      $error("event_flag_bank: overtemperature field overlaps overcurrent field");
   end

   if (POS_OVERCUR_LO + 6 > POS_OVERCUR_RSVD)
   begin : g_bad_overcur
      $error("event_flag_bank: overcurrent field overlaps reserved bit");
   end

   if (POS_HV_OVERCUR >= REG_W)
   begin : g_bad_hv_overcur
      $error("event_flag_bank: high-voltage overcurrent bit beyond register");
   end

   if (RSVD_REGULATOR_FAULT != (16'h0001 << POS_OVERCUR_RSVD))
   begin : g_bad_rsvd_mask
      $error("event_flag_bank: reserved mask does not match reserved position");
   end

   if (POS_WAKE_TWO_RISE != POS_WAKE_ONE_RISE + 1)
   begin : g_bad_wake_rise
      $error("event_flag_bank: wake rise flags must be adjacent");
   end

   if (POS_SUPPLY_UV_LO + 3 > POS_PREREG_LO)
   begin : g_bad_supply_uv
      $error("event_flag_bank: supply field overlaps pre-regulator field");
   end

   if (POS_PREREG_LO + 3 > POS_PREREG_FB_OV)
   begin : g_bad_prereg
      $error("event_flag_bank: pre-regulator field overlaps feedback flag");
   end

   if (POS_CENTRAL_THERMAL >= REG_W)
   begin : g_bad_central
      $error("event_flag_bank: central thermal bit beyond register");
   end

   // the interrupt sum hard-codes bits 12..0 as never inhibited
   if (POS_BIAS_UVH != 13 || POS_SELFTEST_FAIL != 14)
   begin : g_bad_irq_split
      $error("event_flag_bank: interrupt sum assumes bias and self-test at 13 and 14");
   end

   if (POS_INVALID_ACCESS != 0 || POS_CRC_ERROR != 1)
   begin : g_bad_bus_err
      $error("event_flag_bank: bus error flags must sit at bits 0 and 1");
   end

   if (POS_CLOCK_GOOD >= POS_ON_STATE_LO)
   begin : g_bad_clock_good
      $error("event_flag_bank: clock good bit overlaps on-state field");
   end

   if (POS_ON_STATE_LO + 9 > REG_W)
   begin : g_bad_on_state
      $error("event_flag_bank: on-state field beyond register");
   end

   // the inhibit register is taken as one three-bit slice
   if (POS_INH_COMM_ERROR != POS_INH_BIAS_UVH + 1)
   begin : g_bad_inh_comm
      $error("event_flag_bank: inhibit bits must be adjacent");
   end

   if (POS_INH_CENTRAL != POS_INH_BIAS_UVH + 2)
   begin : g_bad_inh_central
      $error("event_flag_bank: inhibit slice must span three bits");
   end

   if (POS_INH_CENTRAL >= REG_W)
   begin : g_bad_inh_top
      $error("event_flag_bank: inhibit slice beyond register");
   end

   // event mapping into the regulator fault flags
   always_comb
   begin
      fault_set = '0;
      fault_set[POS_OVERTEMP_LO +: 8] = overtemp_evt;
      fault_set[POS_OVERCUR_LO +: 6]  = overcurrent_evt[5:0];
      fault_set[POS_HV_OVERCUR]       = overcurrent_evt[6];
   end

   rise_detect #(
      .N (2)
   ) u_wake_rise (
      .clk   (clk),
      .rst_n (rst_n),
      .level ({wake_input_two, wake_input_one}),
      .rise  (wake_rise)
   );

   always_comb
   begin
      wake_set = '0;
      wake_set[POS_WAKE_ONE_RISE]   = wake_rise[0];
      wake_set[POS_WAKE_TWO_RISE]   = wake_rise[1];
      wake_set[POS_SUPPLY_UV_LO +: 3] = supply_uv_evt;
      wake_set[POS_PREREG_LO +: 3]  = prereg_evt;
      wake_set[POS_PREREG_FB_OV]    = prereg_feedback_ov_evt;
      wake_set[POS_HV_INPUT_UV]     = hv_linear_input_uv_evt;
      wake_set[POS_STANDBY_TIMER]   = standby_timer_evt;
      wake_set[POS_BOOST_OV]        = boost_overvoltage_evt;
      wake_set[POS_BOOST_UVH]       = boost_uv_high_evt;
      wake_set[POS_BIAS_UVH]        = bias_rail_uvh_evt;
      wake_set[POS_SELFTEST_FAIL]   = thermal_selftest_fail_evt;
      wake_set[POS_CENTRAL_THERMAL] = central_thermal_evt;
   end

   // an access to an index with no register counts as an invalid access too
   assign unmapped_acc = (acc_wr || acc_rd) && !idx_mapped(acc_idx);
   assign bus_err_set  = {crc_error_evt, invalid_access_evt || unmapped_acc};

   w1c_flag_vec #(
      .WIDTH (16),
      .RSVD  (RSVD_REGULATOR_FAULT),
      .RST   (RST_REGULATOR_FAULT)
   ) u_fault_flags (
      .clk      (clk),
      .rst_n    (rst_n),
      .set_evt  (fault_set),
      .clr_en   (acc_wr && idx_hit(acc_idx, IDX_REGULATOR_FAULT)),
      .clr_data (acc_wdata),
      .flags    (fault_flags)
   );

   w1c_flag_vec #(
      .WIDTH (16),
      .RSVD  (16'h0000),
      .RST   (RST_SUPPLY_WAKE)
   ) u_wake_flags (
      .clk      (clk),
      .rst_n    (rst_n),
      .set_evt  (wake_set),
      .clr_en   (acc_wr && idx_hit(acc_idx, IDX_SUPPLY_WAKE)),
      .clr_data (acc_wdata),
      .flags    (wake_flags)
   );

   // only the two bus error positions of the third register can be cleared
   w1c_flag_vec #(
      .WIDTH (2),
      .RSVD  (16'h0000),
      .RST   (RST_LIVE_STATUS)
   ) u_bus_err_flags (
      .clk      (clk),
      .rst_n    (rst_n),
      .set_evt  (bus_err_set),
      .clr_en   (acc_wr && idx_hit(acc_idx, IDX_LIVE_STATUS)),
      .clr_data (acc_wdata[1:0] & W1C_LIVE_STATUS[1:0]),
      .flags    (bus_err_flags)
   );

   // watchdog status is a register so it reads zero right after reset
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         clock_good_ff <= 1'b0;
      end
      else
      begin
         clock_good_ff <= ext_clock_watchdog_good;
      end
   end

   always_comb
   begin
      live_status = '0;
      live_status[POS_INVALID_ACCESS] = bus_err_flags[0];
      live_status[POS_CRC_ERROR]      = bus_err_flags[1];
      live_status[POS_WAKE_ONE_LIVE]  = wake_input_one;
      live_status[POS_WAKE_TWO_LIVE]  = wake_input_two;
      live_status[POS_CLOCK_GOOD]     = clock_good_ff;
      live_status[POS_ON_STATE_LO +: 9] = regulator_on_state;
   end

   // interrupt inhibit bits for bias rail, communication error, central thermal
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         inhibit_ff <= RST_IRQ_INHIBIT;
      end
      else if (acc_wr && idx_hit(acc_idx, IDX_IRQ_INHIBIT))
      begin
         inhibit_ff <= acc_wdata[POS_INH_CENTRAL -: 3];
      end
   end

   always_comb
   begin
      case (acc_idx)
         IDX_REGULATOR_FAULT: nxt_rdata = fault_flags;
         IDX_SUPPLY_WAKE:     nxt_rdata = wake_flags;
         IDX_LIVE_STATUS:     nxt_rdata = live_status;
         IDX_IRQ_INHIBIT:     nxt_rdata = {inhibit_ff, 13'h0000};
         default:             nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rdata_ff  <= '0;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rvalid_ff <= acc_rd;
         if (acc_rd)
         begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   assign acc_rdata  = rdata_ff;
   assign acc_rvalid = rvalid_ff;

   // flags without an inhibit bit in this bank always reach the request
   always_comb
   begin
      nxt_irq = |fault_flags;
      nxt_irq = nxt_irq | (|wake_flags[12:0]) | wake_flags[POS_SELFTEST_FAIL];
      nxt_irq = nxt_irq | (wake_flags[POS_BIAS_UVH] && !inhibit_ff[0]);
      nxt_irq = nxt_irq | ((|bus_err_flags) && !inhibit_ff[1]);
      nxt_irq = nxt_irq | (wake_flags[POS_CENTRAL_THERMAL] && !inhibit_ff[2]);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         irq_ff <= 1'b0;
      end
      else
      begin
         irq_ff <= nxt_irq;
      end
   end

   assign irq_req = irq_ff;

endmodule

// [logic/evflag_pkg.sv]
// Purpose: shared constants of the main-domain event and status flag bank
// Assumes: 16-bit register payload, which sits in bits 23..8 of a transfer frame
// Notes:   register indices are presented by the control bus frame decoder
package evflag_pkg;

   localparam int unsigned REG_W   = 16;
   localparam int unsigned IDX_W   = 3;

   // register indices on the access port
   localparam logic [2:0] IDX_REGULATOR_FAULT = 3'h0;
   localparam logic [2:0] IDX_SUPPLY_WAKE     = 3'h1;
   localparam logic [2:0] IDX_LIVE_STATUS     = 3'h2;
   localparam logic [2:0] IDX_IRQ_INHIBIT     = 3'h3;

   // reset values
   localparam logic [15:0] RST_REGULATOR_FAULT = 16'h0000;
   localparam logic [15:0] RST_SUPPLY_WAKE     = 16'h0000;
   localparam logic [15:0] RST_LIVE_STATUS     = 16'h0000;
   localparam logic [2:0]  RST_IRQ_INHIBIT     = 3'h0;

   // regulator_fault_flags field positions (payload bit = frame bit - 8)
   localparam int unsigned POS_OVERTEMP_LO     = 0;   // frame bits 15..8
   localparam int unsigned POS_OVERCUR_LO      = 8;   // frame bits 21..16
   localparam int unsigned POS_OVERCUR_RSVD    = 14;  // frame bit 22
   localparam int unsigned POS_HV_OVERCUR      = 15;  // frame bit 23
   localparam logic [15:0] RSVD_REGULATOR_FAULT = 16'h4000;

   // supply_wake_event_flags field positions
   localparam int unsigned POS_WAKE_ONE_RISE   = 0;
   localparam int unsigned POS_WAKE_TWO_RISE   = 1;
   localparam int unsigned POS_SUPPLY_UV_LO    = 2;   // uvh, uvl, uv7 at 2..4
   localparam int unsigned POS_PREREG_LO       = 5;   // uvh, uvl, oc at 5..7
   localparam int unsigned POS_PREREG_FB_OV    = 8;
   localparam int unsigned POS_HV_INPUT_UV     = 9;
   localparam int unsigned POS_STANDBY_TIMER   = 10;
   localparam int unsigned POS_BOOST_OV        = 11;
   localparam int unsigned POS_BOOST_UVH       = 12;
   localparam int unsigned POS_BIAS_UVH        = 13;
   localparam int unsigned POS_SELFTEST_FAIL   = 14;
   localparam int unsigned POS_CENTRAL_THERMAL = 15;

   // live_status_and_bus_errors field positions
   localparam int unsigned POS_INVALID_ACCESS  = 0;
   localparam int unsigned POS_CRC_ERROR       = 1;
   localparam int unsigned POS_WAKE_ONE_LIVE   = 2;
   localparam int unsigned POS_WAKE_TWO_LIVE   = 3;
   localparam int unsigned POS_CLOCK_GOOD      = 6;
   localparam int unsigned POS_ON_STATE_LO     = 7;   // frame bits 23..15
   localparam logic [15:0] W1C_LIVE_STATUS     = 16'h0003;

   // irq inhibit register: frame bits 23..21 of the second mask register
   localparam int unsigned POS_INH_BIAS_UVH    = 13;
   localparam int unsigned POS_INH_COMM_ERROR  = 14;
   localparam int unsigned POS_INH_CENTRAL     = 15;

endpackage

// [logic/w1c_flag_vec.sv]
// Purpose: vector of sticky event flags, cleared by writing one
// Assumes: set pulses and clear strobe are synchronous to clk
// Notes:   reserved positions never store anything and read zero
module w1c_flag_vec #(
   parameter int unsigned  WIDTH = 16,
   parameter logic [15:0]  RSVD  = 16'h0000,
   parameter logic [15:0]  RST   = 16'h0000
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] set_evt,
   input  wire logic             clr_en,
   input  wire logic [WIDTH-1:0] clr_data,
   output logic      [WIDTH-1:0] flags
);

   logic [WIDTH-1:0] flag_ff;
   logic [WIDTH-1:0] nxt_flag;

   if (WIDTH == 0 || WIDTH > 16)
   begin : g_bad_width
      $error("w1c_flag_vec: WIDTH must be 1..16");
   end

   // a new event in the clearing cycle keeps the flag set
   always_comb
   begin
      nxt_flag = flag_ff;
      if (clr_en)
      begin
         nxt_flag = flag_ff & ~clr_data;
      end
      nxt_flag = (nxt_flag | set_evt) & ~RSVD[WIDTH-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         flag_ff <= RST[WIDTH-1:0];
      end
      else
      begin
         flag_ff <= nxt_flag;
      end
   end

   assign flags = flag_ff;

endmodule

// [logic/rise_detect.sv]
// Purpose: low-to-high transition detector for a group of input levels
// Assumes: inputs already synchronous to clk
// Notes:   the first cycle after reset only samples, so a level that is
//          already high at reset release does not count as a transition
module rise_detect #(
   parameter int unsigned N = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [N-1:0] level,
   output logic      [N-1:0] rise
);

   logic [N-1:0] prev_ff;
   logic         armed_ff;

   if (N == 0)
   begin : g_bad_n
      $error("rise_detect: N must be at least 1");
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prev_ff  <= '0;
         armed_ff <= 1'b0;
      end
      else
      begin
         prev_ff  <= level;
         armed_ff <= 1'b1;
      end
   end

   assign rise = armed_ff ? (level & ~prev_ff) : '0;

endmodule

// [bench/evflag_bank_asserts.sv]
// Purpose: port-level checks of the event flag bank
// Assumes: inhibit bits at reset value unless a scenario writes them
// Notes:   live wake and on-state levels are checked as seen at the read edge, clock good as seen one edge earlier
module evflag_bank_asserts
   import evflag_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic             acc_rd,
   input wire logic             acc_wr,
   input wire logic [IDX_W-1:0] acc_idx,
   input wire logic [REG_W-1:0] acc_rdata,
   input wire logic             acc_rvalid,
   input wire logic [7:0]       overtemp_evt,
   input wire logic [6:0]       overcurrent_evt,
   input wire logic [2:0]       supply_uv_evt,
   input wire logic             wake_input_one,
   input wire logic             wake_input_two,
   input wire logic             ext_clock_watchdog_good,
   input wire logic [8:0]       regulator_on_state,
   input wire logic             irq_req
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd2;
      acc_rd && acc_idx == IDX_LIVE_STATUS;
   endsequence
   property p_ot_irq; overtemp_evt != 8'h00 |-> ##2 irq_req; endproperty
   a_ot_irq: assert property (p_ot_irq) else $error("no irq after overtemp event");
   property p_oc_irq; overcurrent_evt != 7'h00 |-> ##2 irq_req; endproperty
   a_oc_irq: assert property (p_oc_irq) else $error("no irq after overcurrent event");
   property p_sup_irq; supply_uv_evt != 3'h0 |-> ##2 irq_req; endproperty
   a_sup_irq: assert property (p_sup_irq) else $error("no irq after supply event");
   property p_wake_irq; $rose(wake_input_one) && $past(rst_n, 3) |-> ##[1:2] irq_req; endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("no irq after wake rise");
   property p_live_wake; s_rd2 |=> acc_rdata[3:2] == $past({wake_input_two, wake_input_one}); endproperty
   a_live_wake: assert property (p_live_wake) else $error("wake level readback wrong");
   property p_live_on; s_rd2 |=> acc_rvalid && acc_rdata[15:7] == $past(regulator_on_state); endproperty
   a_live_on: assert property (p_live_on) else $error("on state readback wrong");
   property p_clk_good; s_rd2 ##0 $past(rst_n) |=> acc_rdata[6] == $past(ext_clock_watchdog_good, 2); endproperty
   a_clk_good: assert property (p_clk_good) else $error("clock good readback wrong");
   property p_rsvd; s_rd2 |=> acc_rdata[5:4] == 2'b00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved status bits not zero");
   property p_fault_rsvd; acc_rd && acc_idx == IDX_REGULATOR_FAULT |=> !acc_rdata[14]; endproperty
   a_fault_rsvd: assert property (p_fault_rsvd) else $error("reserved fault bit not zero");
   property p_unmapped; acc_rd && acc_idx[2] |=> acc_rvalid && acc_rdata == 16'h0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   c_inhibit: cover property (acc_wr && acc_idx == IDX_IRQ_INHIBIT);
   c_irq_fall: cover property ($fell(irq_req));
   c_unmapped: cover property (acc_rd && acc_idx[2]);
endmodule

// [bench/evflag_host.sv]
// Purpose: host side of the register access port
// Assumes: one access at a time, strobes lowered on the edge that takes them
// Notes:   write data is inverted once released so stale values never match
module evflag_host
   import evflag_pkg::*;
(
   input  wire logic             clk,
   output logic                  acc_wr,
   output logic                  acc_rd,
   output logic      [IDX_W-1:0] acc_idx,
   output logic      [REG_W-1:0] acc_wdata,
   input  wire logic [REG_W-1:0] acc_rdata,
   input  wire logic             acc_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      acc_wr = 1'b0;
      acc_rd = 1'b0;
      acc_idx = 3'h0;
      acc_wdata = 16'h0000;
   end
   task automatic wr(input logic [2:0] idx, input logic [15:0] d);
      @(posedge clk);
      acc_wr <= 1'b1;
      acc_idx <= idx;
      acc_wdata <= d;
      @(posedge clk);
      acc_wr <= 1'b0;
      acc_wdata <= ~d;
   endtask
   // answer is looked at 1 ns after the edge where it stands
   task automatic rd(input logic [2:0] idx, output logic [15:0] d, output logic ok);
      @(posedge clk);
      acc_rd <= 1'b1;
      acc_idx <= idx;
      @(posedge clk);
      acc_rd <= 1'b0;
      #1;
      ok = acc_rvalid;
      d = acc_rdata;
   endtask
   task automatic startup_clear();
      wr(IDX_REGULATOR_FAULT, 16'hffff);
      wr(IDX_SUPPLY_WAKE, 16'hffff);
      wr(IDX_LIVE_STATUS, 16'hffff);
   endtask
endmodule

// [bench/event_flag_bank_tb.sv]
// Purpose: self-checking bench of the event flag bank
// Assumes: inhibit register at reset value except in the mask test
// Notes:   events live in one flat vector so one loop walks every flag but the two wake rise flags
module event_flag_bank_tb
   import evflag_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_n, acc_wr, acc_rd, acc_rvalid, irq_req, rok;
   logic        wake_input_one, wake_input_two, ext_clock_watchdog_good;
   logic [2:0]  acc_idx;
   logic [15:0] acc_wdata, acc_rdata, rdat;
   logic [8:0]  regulator_on_state;
   logic [30:0] evt_v;
   int          mismatches, compares, cycles;
   evflag_host i_evflag_host (.clk, .acc_wr, .acc_rd, .acc_idx, .acc_wdata, .acc_rdata, .acc_rvalid);
   event_flag_bank i_event_flag_bank (.clk, .rst_n, .acc_wr, .acc_rd, .acc_idx, .acc_wdata, .acc_rdata,
      .acc_rvalid, .overtemp_evt(evt_v[7:0]), .overcurrent_evt(evt_v[14:8]), .supply_uv_evt(evt_v[17:15]),
      .prereg_evt(evt_v[20:18]), .prereg_feedback_ov_evt(evt_v[21]), .hv_linear_input_uv_evt(evt_v[22]),
      .standby_timer_evt(evt_v[23]), .boost_overvoltage_evt(evt_v[24]), .boost_uv_high_evt(evt_v[25]),
      .bias_rail_uvh_evt(evt_v[26]), .thermal_selftest_fail_evt(evt_v[27]), .central_thermal_evt(evt_v[28]),
      .invalid_access_evt(evt_v[29]), .crc_error_evt(evt_v[30]), .wake_input_one, .wake_input_two,
      .ext_clock_watchdog_good, .regulator_on_state, .irq_req);
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // a full run costs far fewer cycles than this ceiling
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [2:0] idx, input logic [15:0] exp);
      i_evflag_host.rd(idx, rdat, rok);
      check({15'h0000, rok}, 16'h0001);
      check(rdat, exp);
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      evt_v <= 31'h1 << k;
      @(posedge clk);
      evt_v <= '0;
   endtask
   function automatic logic [2:0] ev_idx(input int k);
      return (k < 15) ? IDX_REGULATOR_FAULT : (k < 29) ? IDX_SUPPLY_WAKE : IDX_LIVE_STATUS;
   endfunction
   function automatic logic [15:0] ev_bit(input int k);
      if (k < 15)
         return 16'h0001 << ((k == 14) ? 15 : k);
      return (k < 29) ? 16'h0001 << (k - 13) : 16'h0001 << (k - 29);
   endfunction
   initial
   begin
      logic [15:0] m;
      logic [8:0]  on;
      logic        w1, w2, g;
      rst_n = 1'b0;
      evt_v = '0;
      {wake_input_one, wake_input_two, ext_clock_watchdog_good, regulator_on_state} = '0;
      void'($urandom(32'h83f38f28));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++)
         rdchk(i[2:0], 16'h0000);
      i_evflag_host.startup_clear();
      $display("done: reset values");
      for (int k = 0; k < 31; k++)
      begin
         m = ev_bit(k);
         pulse(k);
         rdchk(ev_idx(k), m);
         check({15'h0000, irq_req}, 16'h0001);
         i_evflag_host.wr(ev_idx(k), 16'($urandom()) & ~m);
         rdchk(ev_idx(k), m);
         i_evflag_host.wr(ev_idx(k), m);
         rdchk(ev_idx(k), 16'h0000);
         check({15'h0000, irq_req}, 16'h0000);
      end
      $display("done: flag walk");
      for (int i = 0; i < 6; i++)
      begin
         on = 9'($urandom());
         {w2, w1, g} = 3'($urandom());
         m = {14'h0000, w2 & ~wake_input_two, w1 & ~wake_input_one};
         @(posedge clk);
         {wake_input_two, wake_input_one, ext_clock_watchdog_good, regulator_on_state} <= {w2, w1, g, on};
         rdchk(IDX_SUPPLY_WAKE, m);
         rdchk(IDX_LIVE_STATUS, {on, g, 2'b00, w2, w1, 2'b00});
         i_evflag_host.wr(IDX_LIVE_STATUS, 16'hfffc);
         rdchk(IDX_LIVE_STATUS, {on, g, 2'b00, w2, w1, 2'b00});
         i_evflag_host.wr(IDX_SUPPLY_WAKE, 16'h0003);
      end
      @(posedge clk);
      {wake_input_two, wake_input_one, ext_clock_watchdog_good, regulator_on_state} <= '0;
      $display("done: live status");
      i_evflag_host.wr(IDX_IRQ_INHIBIT, 16'he000);
      rdchk(IDX_IRQ_INHIBIT, 16'he000);
      pulse(30);
      pulse(28);
      pulse(26);
      rdchk(IDX_LIVE_STATUS, 16'h0002);
      check({15'h0000, irq_req}, 16'h0000);
      i_evflag_host.wr(IDX_IRQ_INHIBIT, 16'h0000);
      rdchk(IDX_SUPPLY_WAKE, 16'ha000);
      check({15'h0000, irq_req}, 16'h0001);
      i_evflag_host.wr(IDX_SUPPLY_WAKE, 16'hffff);
      i_evflag_host.wr(IDX_LIVE_STATUS, 16'hffff);
      rdchk(IDX_SUPPLY_WAKE, 16'h0000);
      check({15'h0000, irq_req}, 16'h0000);
      $display("done: inhibit");
      fork
         i_evflag_host.wr(IDX_REGULATOR_FAULT, 16'hffff);
         pulse(0);
      join
      rdchk(IDX_REGULATOR_FAULT, 16'h0001);
      i_evflag_host.wr(IDX_REGULATOR_FAULT, 16'h0001);
      $display("done: set beats clear");
      rdchk(3'h5, 16'h0000);
      i_evflag_host.wr(3'h7, 16'hffff);
      rdchk(IDX_LIVE_STATUS, 16'h0001);
      i_evflag_host.wr(IDX_LIVE_STATUS, 16'h0001);
      rdchk(IDX_LIVE_STATUS, 16'h0000);
      $display("done: unmapped access");
      end_of_test();
   end
endmodule
bind event_flag_bank evflag_bank_asserts i_evflag_bank_asserts (.clk, .rst_n, .acc_rd, .acc_wr, .acc_idx,
   .acc_rdata, .acc_rvalid, .overtemp_evt, .overcurrent_evt, .supply_uv_evt, .wake_input_one, .wake_input_two,
   .ext_clock_watchdog_good, .regulator_on_state, .irq_req);
